// >>> tb/csm_main_osc_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Main clock oscillator under supervision
// ==========================================================================
module csm_main_osc_model #(
  parameter int HALF_NS = 20  // Half period, 25 MHz, below core_clk/2
) (
  input  wire logic run,
  output logic      clkOut
);
  // Toggles while running; a stopped oscillator rests low, never mid-swing
  initial begin
    clkOut = 1'b0;
    forever begin
      #(HALF_NS);
      if (run) begin
        clkOut = ~clkOut;
      end else begin
        clkOut = 1'b0;
      end
    end
  end
endmodule // csm_main_osc_model

// >>> tb/test_main_clock_stop_monitor.sv
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the main clock stop monitor
// ==========================================================================
module test_main_clock_stop_monitor
  import csm_pkg::*;
;
  logic        core_clk, rst_b, hsel, hwrite, hreadyout, hresp;  // Bus and clock
  logic [31:0] haddr, hwdata, hrdata, rd;                         // Bus words
  logic [1:0]  htrans;                                            // Transfer type
  logic [2:0]  hsize;                                             // Always word
  logic        mainClkIn, intOscClkIn, mainRun, oscRun;           // Clock sources
  logic        stopMode, oscSettling, mainOscStopBit, subclockSelStatus;
  logic        internalOscStopBit, cpuOnInternalOsc;              // Pause causes
  logic        sysResetReq, monitorActive, irq;                   // Outputs
  logic        resetSeen = 1'b0;                                  // Any request seen
  int          error_cnt = 0;                                     // Mismatches
  int          n_checks  = 0;                                     // Comparisons
  int          cyc       = 0;                                     // Cycle count
  int          riseAt    = -1;                                    // Request start
  int          pulseLen  = 0;                                     // Request width
  int          t0;                                                // Stop moment

  // ========================================================================
  // Design and partner
  // ========================================================================
  main_clock_stop_monitor dut (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mainClkIn(mainClkIn),
    .intOscClkIn(intOscClkIn), .stopMode(stopMode), .oscSettling(oscSettling),
    .mainOscStopBit(mainOscStopBit), .subclockSelStatus(subclockSelStatus),
    .internalOscStopBit(internalOscStopBit), .cpuOnInternalOsc(cpuOnInternalOsc),
    .sysResetReq(sysResetReq), .monitorActive(monitorActive), .irq(irq));
  csm_main_osc_model osc (.run(mainRun), .clkOut(mainClkIn));

  // ========================================================================
  // Clocks: core 8 ns, sampling oscillator 104 ns, exactly 13 core periods, so fixed in phase
  // ========================================================================
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    intOscClkIn = 1'b0;
    forever begin
      #52;
      if (oscRun) begin
        intOscClkIn = ~intOscClkIn;  // Gated to model a stopped oscillator
      end
    end
  end

  // Records every reset request cycle
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (sysResetReq === 1'b1) begin
      resetSeen <= 1'b1;
      pulseLen  <= pulseLen + 1;
      if (riseAt < 0) begin
        riseAt <= cyc;
      end
    end
  end

  // ========================================================================
  // Tasks
  // ========================================================================
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Waits for hready at an edge; a stuck bus counts as a mismatch
  task automatic waitRdy();
    int n;
    n = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 100) begin
      error_cnt++;
      $display("[FAIL] hready expected 1 seen %b", hreadyout);
    end
  endtask

  // One single word transfer, address phase then data phase
  task automatic busXfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize  <= CSM_HSIZE_WORD;
    waitRdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    busXfer(1'b1, a, d);
  endtask

  // Unlock key, then the guarded mode write
  task automatic unlockWr(input logic [31:0] d);
    wr(CSM_ADDR_PROTECT, {24'h0, CSM_PROTECT_KEY});
    wr(CSM_ADDR_MODE, d);
  endtask

  task automatic chkWord(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkBit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic rdChk(input string nm, input logic [31:0] a, input logic [31:0] e);
    busXfer(1'b0, a, 32'h0);
    chkWord(nm, e, rd);
  endtask

  // Raises or drops one pause cause; index 5 halts the sampling clock
  task automatic setPause(input int i, input logic v);
    case (i)
      0: stopMode <= v;
      1: oscSettling <= v;
      2: internalOscStopBit <= v;
      3: cpuOnInternalOsc <= v;
      4: begin
        mainOscStopBit    <= v;
        subclockSelStatus <= v;
      end
      default: oscRun <= !v;
    endcase
  endtask

  task automatic results();
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Whole run needs about 20 us; allow far more before calling it a hang
  initial begin
    #200000;
    error_cnt++;
    results();
  end

  // ========================================================================
  // Main sequence
  // ========================================================================
  initial begin
    {rst_b, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = CSM_HSIZE_WORD;
    {mainRun, oscRun} = 2'b11;  // Main clock settled before software enables
    {stopMode, oscSettling, mainOscStopBit, subclockSelStatus} = '0;
    {internalOscStopBit, cpuOnInternalOsc} = '0;
    tick(16);
    rst_b <= 1'b1;
    tick(4);
    rdChk("modeReset", CSM_ADDR_MODE, {24'h0, CSM_MODE_RESET});
    rdChk("flagReset", CSM_ADDR_RESET_SRC, 32'h0);
    chkBit("monIdle", 1'b0, monitorActive);
    chkBit("respOkay", 1'b0, hresp);
    wr(CSM_ADDR_INT_STATUS, 32'hffffffff);
    rdChk("statusRo", CSM_ADDR_INT_STATUS, 32'h0);
    rdChk("unmapped", 32'hfffff8f0, 32'h0);
    // Ordinary write must be dropped and flagged
    wr(CSM_ADDR_MODE, 32'h1);
    rdChk("modeLocked", CSM_ADDR_MODE, 32'h0);
    wr(CSM_ADDR_INT_ENABLE, 32'h3);
    tick(2);
    chkBit("irqLocked", 1'b1, irq);
    wr(CSM_ADDR_INT_ENABLE, 32'h1);
    tick(2);
    chkBit("irqMasked", 1'b0, irq);
    wr(CSM_ADDR_INT_CLEAR, 32'h2);
    rdChk("statusClr", CSM_ADDR_INT_STATUS, 32'h0);
    // Guarded enable; upper bits must read zero
    unlockWr(32'hff);
    rdChk("modeOn", CSM_ADDR_MODE, 32'h1);
    tick(4);
    chkBit("monOn", 1'b1, monitorActive);
    unlockWr(32'h0);
    rdChk("modeKept", CSM_ADDR_MODE, 32'h1);
    // Sub-idle with main running keeps watching
    subclockSelStatus <= 1'b1;
    tick(200);
    chkBit("monSubIdle", 1'b1, monitorActive);
    chkBit("noResetIdle", 1'b0, resetSeen);
    subclockSelStatus <= 1'b0;
    // Each pause cause hides a main clock stop, then monitoring resumes
    for (int i = 0; i < 6; i++) begin
      setPause(i, 1'b1);
      tick(4);
      mainRun <= 1'b0;
      tick(250);
      chkBit($sformatf("monPaused%0d", i), 1'b0, monitorActive);
      chkBit($sformatf("noReset%0d", i), 1'b0, resetSeen);
      mainRun <= 1'b1;
      tick(20);
      setPause(i, 1'b0);
      tick(40);
      chkBit($sformatf("monResumed%0d", i), 1'b1, monitorActive);
    end
    // Real stop: request within the threshold window, fixed width
    riseAt   = -1;
    pulseLen = 0;
    t0 = cyc;
    mainRun <= 1'b0;
    tick(150);
    chkBit("stopWindow", 1'b1, riseAt - t0 >= 30 && riseAt - t0 <= 100);
    chkWord("resetWidth", 32'(CSM_RESET_HOLD_CYCLES), pulseLen);
    rdChk("modeCleared", CSM_ADDR_MODE, 32'h0);
    rdChk("flagSet", CSM_ADDR_RESET_SRC, 32'h1);
    chkBit("monOff", 1'b0, monitorActive);
    chkBit("irqStop", 1'b1, irq);
    wr(CSM_ADDR_INT_CLEAR, 32'h1);
    wr(CSM_ADDR_RESET_SRC, 32'h1);
    rdChk("flagCleared", CSM_ADDR_RESET_SRC, 32'h0);
    tick(2);
    chkBit("irqCleared", 1'b0, irq);
    // External reset mid-monitoring
    mainRun <= 1'b1;
    tick(20);
    unlockWr(32'h1);
    tick(4);
    chkBit("monOnAgain", 1'b1, monitorActive);
    rst_b <= 1'b0;
    tick(2);
    chkBit("monInReset", 1'b0, monitorActive);
    rst_b <= 1'b1;
    tick(4);
    rdChk("modeAfterRst", CSM_ADDR_MODE, 32'h0);
    results();
  end
endmodule // test_main_clock_stop_monitor

// >>> verilog/csm_edge_watch.sv
`timescale 1ns/1ps
// ==========================================================================
// Three-stage synchroniser with rising-edge pulse
// ==========================================================================
module csm_edge_watch
  import csm_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic asyncIn,
  output logic      edgePulse
);

  // State of the synchroniser
  typedef struct packed {
    logic s1;     // First stage, read only by s2
    logic s2;     // Second stage
    logic s3;     // Third stage
    logic lvl;    // Accepted level
    logic pulse;  // Rising edge seen
  } csm_sync_t;

  csm_sync_t st_q;  // Registered state
  csm_sync_t st_d;  // Next state

  // ========================================================================
  // Next state
  // ========================================================================
  // A change counts only once stages two and three agree
  always_comb begin
    st_d       = st_q;
    st_d.s1    = asyncIn;
    st_d.s2    = st_q.s1;
    st_d.s3    = st_q.s2;
    st_d.pulse = 1'b0;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl   = st_q.s3;
      st_d.pulse = st_q.s3 & ~st_q.lvl;  // Rising edge only
    end
  end

  // ========================================================================
  // Registers
  // ========================================================================
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign edgePulse = st_q.pulse;

endmodule // csm_edge_watch

// >>> verilog/csm_pkg.sv
// ==========================================================================
// Shared constants for the main clock stop monitor
// ==========================================================================
package csm_pkg;

  // ========================================================================
  // Register byte addresses on the AHB-Lite slave
  // ========================================================================
  localparam logic [31:0] CSM_ADDR_MODE       = 32'hfffff870; // clock_supervisor_mode
  localparam logic [31:0] CSM_ADDR_RESET_SRC  = 32'hfffff874; // reset_source_register
  localparam logic [31:0] CSM_ADDR_PROTECT    = 32'hfffff878; // Unlock key register
  localparam logic [31:0] CSM_ADDR_INT_STATUS = 32'hfffff87c; // Sticky events, read only
  localparam logic [31:0] CSM_ADDR_INT_ENABLE = 32'hfffff880; // Interrupt enables
  localparam logic [31:0] CSM_ADDR_INT_CLEAR  = 32'hfffff884; // Write one to clear

  // ========================================================================
  // Fields and reset values
  // ========================================================================
  localparam logic [7:0]  CSM_PROTECT_KEY     = 8'ha5;   // Unlocks the next write
  localparam logic [7:0]  CSM_MODE_RESET      = 8'h00;   // Mode register after reset
  localparam int          CSM_ENABLE_BIT      = 0;       // monitor_enable position
  localparam int          CSM_RSTFLAG_BIT     = 0;       // monitor_reset_flag position
  localparam int          CSM_INT_STOP_BIT    = 0;       // Stop-detect event
  localparam int          CSM_INT_PROT_BIT    = 1;       // Discarded write event
  localparam int          CSM_INT_W           = 2;       // Number of events
  localparam logic [2:0]  CSM_HSIZE_WORD      = 3'h2;    // Largest size accepted

  // ========================================================================
  // Timing
  // ========================================================================
  localparam int          CSM_CLK_PERIOD_PS   = 8000;    // core_clk, 125 MHz
  localparam logic [2:0]  CSM_STOP_OSC_PERIODS = 3'h4;   // Osc periods without main edge
  localparam int          CSM_OSC_LOST_NS     = 1000;    // No osc edge this long: osc stopped
  localparam logic [7:0]  CSM_OSC_LOST_CYCLES =
    8'((CSM_OSC_LOST_NS * 1000 + CSM_CLK_PERIOD_PS - 1) / CSM_CLK_PERIOD_PS);
  localparam int          CSM_RESET_HOLD_NS   = 128;     // Width of the reset request
  localparam logic [4:0]  CSM_RESET_HOLD_CYCLES =
    5'((CSM_RESET_HOLD_NS * 1000) / CSM_CLK_PERIOD_PS);

  // ========================================================================
  // Monitor states
  // ========================================================================
  typedef enum logic [3:0] {
    CSM_MON_OFF   = 4'b0001,  // Enable bit clear
    CSM_MON_WATCH = 4'b0010,  // Counting osc periods between main edges
    CSM_MON_PAUSE = 4'b0100,  // A stop condition holds
    CSM_MON_RESET = 4'b1000   // Reset request driven
  } csm_mon_t;

endpackage

// >>> verilog/main_clock_stop_monitor.sv
`timescale 1ns/1ps
// Functional notes
// RL1 - Main clock stops while enabled: request reset
// RL2 - Software cannot clear a set enable
// RL3 - Monitor reset clears enable, sets flag
// RL4 - Mode writes need the unlock sequence
// RL5 - Mode register byte wide, zero upper bits
// RL6 - Enable bit one starts monitoring
// RL7 - Pause in STOP and settling, resume automatically
// RL8 - Pause from main stop until main selected
// RL9 - Pause while the sampling oscillator stops
// RL10 - Pause while CPU runs from internal oscillator
// RL11 - Keep watching in HALT and idle modes
// RL12 - External reset clears enable, monitor stopped
// RL13 - Software enables after main clock settles
// RL14 - Restart monitoring when main clock restarts
// RL15 - Stop means osc periods without main edge
module main_clock_stop_monitor
  import csm_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        mainClkIn,
  input  wire logic        intOscClkIn,
  input  wire logic        stopMode,
  input  wire logic        oscSettling,
  input  wire logic        mainOscStopBit,
  input  wire logic        subclockSelStatus,
  input  wire logic        internalOscStopBit,
  input  wire logic        cpuOnInternalOsc,
  output logic             sysResetReq,
  output logic             monitorActive,
  output logic             irq
);

  // ========================================================================
  // State
  // ========================================================================
  // Every flip-flop of the block, except those inside the two edge watchers, lives in this one record
  typedef struct packed {
    csm_mon_t              mon;       // Monitor state
    logic                  enable;    // monitor_enable
    logic                  unlock;    // Key seen, next write may hit mode
    logic                  rstFlag;   // monitor_reset_flag
    logic [CSM_INT_W-1:0]  intSt;     // Sticky events
    logic [CSM_INT_W-1:0]  intEn;     // Event enables
    logic                  mainHold;  // Main clock deliberately stopped
    logic [2:0]            oscCnt;    // Osc edges since last main edge
    logic [7:0]            idleCnt;   // Core cycles since last osc edge
    logic [4:0]            rstCnt;    // Reset request width
    logic                  wrPend;    // Write data phase follows
    logic [31:0]           wrAddr;    // Address of that write
    logic [31:0]           rdata;     // Read data for the data phase
    logic                  ready;     // Always ready, zero wait states
    logic                  resp;      // Always OKAY
    logic                  irqOut;    // Interrupt level
    logic                  active;    // Watching right now
    logic                  rstReq;    // Reset request level
  } csm_state_t;

  csm_state_t st_q;      // Registered state
  csm_state_t st_d;      // Next state
  logic       mainEdge;  // Main clock rising edge, synchronised
  logic       oscEdge;   // Internal osc rising edge, synchronised
  logic       addrPhase; // Address phase taken this cycle
  logic       pauseNow;  // Some stop condition holds
  logic       oscLost;   // Sampling clock gone quiet
  logic       stopSeen;  // Main clock judged stopped
  logic       modeWrite; // Unlocked write to the mode register
  logic       protErr;   // Locked write to the mode register
  logic [CSM_INT_W-1:0] intClr; // Clear strobes from software

  // ========================================================================
  // Clock samplers
  // ========================================================================
  // Both clocks are foreign to core_clk, so each is synchronised first
  csm_edge_watch u_main_watch (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .asyncIn   (mainClkIn),
    .edgePulse (mainEdge)
  );

  csm_edge_watch u_osc_watch (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .asyncIn   (intOscClkIn),
    .edgePulse (oscEdge)
  );

  // ========================================================================
  // Next state
  // ========================================================================
  always_comb begin
    st_d      = st_q;
    st_d.ready = 1'b1;
    st_d.resp  = 1'b0;
    addrPhase = hsel && htrans[1] && hready && (hsize <= CSM_HSIZE_WORD);
    modeWrite = 1'b0;
    protErr   = 1'b0;
    intClr    = '0;

    // Write data phase
    if (st_q.wrPend) begin
      st_d.unlock = (st_q.wrAddr == CSM_ADDR_PROTECT) && (hwdata[7:0] == CSM_PROTECT_KEY);
      case (st_q.wrAddr)
        CSM_ADDR_MODE: begin
          if (st_q.unlock) begin
            modeWrite = 1'b1;  // see RL4
          end else begin
            protErr = 1'b1;    // Ordinary write dropped, see RL4
          end
        end
        CSM_ADDR_RESET_SRC: begin
          if (hwdata[CSM_RSTFLAG_BIT]) begin
            st_d.rstFlag = 1'b0;
          end
        end
        CSM_ADDR_INT_ENABLE: begin
          st_d.intEn = hwdata[CSM_INT_W-1:0];
        end
        CSM_ADDR_INT_CLEAR: begin
          intClr = hwdata[CSM_INT_W-1:0];
        end
        default: begin
          // Unmapped or read-only: ignored
        end
      endcase
    end

    // Only a one can be stored; a zero never clears the bit
    if (modeWrite && hwdata[CSM_ENABLE_BIT]) begin
      st_d.enable = 1'b1;  // see RL2, see RL6
    end

    // Address phase capture
    st_d.wrPend = addrPhase && hwrite;
    if (addrPhase) begin
      st_d.wrAddr = haddr;
    end
    st_d.rdata = 32'h0;
    if (addrPhase && !hwrite) begin
      case (haddr)
        CSM_ADDR_MODE:       st_d.rdata = {24'h0, CSM_MODE_RESET[7:1], st_q.enable}; // see RL5
        CSM_ADDR_RESET_SRC:  st_d.rdata = {31'h0, st_q.rstFlag};
        CSM_ADDR_INT_STATUS: st_d.rdata = {30'h0, st_q.intSt};
        CSM_ADDR_INT_ENABLE: st_d.rdata = {30'h0, st_q.intEn};
        default:             st_d.rdata = 32'h0;
      endcase
    end

    // Deliberate main stop lasts until main clock is selected again
    if (mainOscStopBit && subclockSelStatus) begin
      st_d.mainHold = 1'b1;  // see RL8
    end else if (!subclockSelStatus) begin
      st_d.mainHold = 1'b0;  // see RL8, see RL14
    end

    // Quiet sampling clock means no judgement can be made
    if (oscEdge) begin
      st_d.idleCnt = 8'h0;
    end else if (st_q.idleCnt != CSM_OSC_LOST_CYCLES) begin
      st_d.idleCnt = st_q.idleCnt + 8'h1;
    end
    oscLost = (st_q.idleCnt == CSM_OSC_LOST_CYCLES);  // see RL9

    // HALT and idle modes are not listed, so they keep watching
    pauseNow = stopMode || oscSettling || st_q.mainHold ||  // see RL7, see RL8, see RL11
               internalOscStopBit || oscLost ||              // see RL9
               cpuOnInternalOsc;                             // see RL10

    // Count osc periods between main edges
    stopSeen = (st_q.mon == CSM_MON_WATCH) && !pauseNow && !mainEdge && oscEdge &&
               (st_q.oscCnt == CSM_STOP_OSC_PERIODS - 3'h1);  // see RL15
    if (mainEdge || pauseNow || (st_q.mon != CSM_MON_WATCH)) begin
      st_d.oscCnt = 3'h0;  // Fresh count after any pause
    end else if (oscEdge && (st_q.oscCnt != CSM_STOP_OSC_PERIODS)) begin
      st_d.oscCnt = st_q.oscCnt + 3'h1;
    end

    // Monitor sequencing
    case (st_q.mon)
      CSM_MON_OFF: begin
        if (st_q.enable && !pauseNow) begin
          st_d.mon = CSM_MON_WATCH;  // see RL6
        end else if (st_q.enable) begin
          st_d.mon = CSM_MON_PAUSE;
        end
      end
      CSM_MON_WATCH: begin
        if (stopSeen) begin
          st_d.mon    = CSM_MON_RESET;  // see RL1
          st_d.rstCnt = 5'h0;
        end else if (pauseNow) begin
          st_d.mon = CSM_MON_PAUSE;  // see RL7
        end
      end
      CSM_MON_PAUSE: begin
        if (!pauseNow) begin
          st_d.mon = CSM_MON_WATCH;  // Automatic resume, see RL7, see RL14
        end
      end
      CSM_MON_RESET: begin
        st_d.rstCnt = st_q.rstCnt + 5'h1;
        if (st_q.rstCnt == CSM_RESET_HOLD_CYCLES - 5'h1) begin
          st_d.mon = CSM_MON_OFF;
        end
      end
      default: begin
        st_d.mon = CSM_MON_OFF;
      end
    endcase

    // Monitor reset drops enable and records its source
    if (st_d.mon == CSM_MON_RESET) begin
      st_d.enable = 1'b0;  // see RL3
    end
    if (stopSeen) begin
      st_d.rstFlag = 1'b1;  // Set wins over clear, see RL3
    end

    // Sticky events; a new event beats a clear in the same cycle
    st_d.intSt = (st_q.intSt & ~intClr);
    st_d.intSt[CSM_INT_STOP_BIT] = st_d.intSt[CSM_INT_STOP_BIT] | stopSeen;
    st_d.intSt[CSM_INT_PROT_BIT] = st_d.intSt[CSM_INT_PROT_BIT] | protErr;

    st_d.rstReq = (st_d.mon == CSM_MON_RESET);
    st_d.active = (st_d.mon == CSM_MON_WATCH);
    st_d.irqOut = |(st_d.intSt & st_d.intEn);
  end

  // ========================================================================
  // Registers
  // ========================================================================
  // Synchronous reset: enable cleared and monitor held off, see RL12
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_q       <= '0;
      st_q.mon   <= CSM_MON_OFF;
      st_q.ready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ========================================================================
  // Outputs, all straight from flip-flops
  // ========================================================================
  assign hreadyout     = st_q.ready;
  assign hrdata        = st_q.rdata;
  assign hresp         = st_q.resp;
  assign sysResetReq   = st_q.rstReq;
  assign monitorActive = st_q.active;
  assign irq           = st_q.irqOut;

  // ========================================================================
  // Assertions
  // ========================================================================
  // Steps of a monitor-triggered reset
  sequence s_stop_judged;
    stopSeen;
  endsequence

  sequence s_reset_pulse;
    sysResetReq [*8];
  endsequence

  a_stop_to_reset: assert property (@(posedge core_clk) disable iff (!rst_b) // see RL1
    s_stop_judged |=> s_reset_pulse)
    else $error("stop detection did not raise reset request");

  a_enable_sticky: assert property (@(posedge core_clk) disable iff (!rst_b) // see RL2
    st_q.enable && !stopSeen |=> st_q.enable)
    else $error("enable bit cleared without reset");

  a_reset_clears_en: assert property (@(posedge core_clk) disable iff (!rst_b) // see RL3
    $rose(sysResetReq) |-> !st_q.enable && st_q.rstFlag)
    else $error("monitor reset left enable set or flag clear");

  a_locked_write: assert property (@(posedge core_clk) disable iff (!rst_b) // see RL4
    st_q.wrPend && (st_q.wrAddr == CSM_ADDR_MODE) && !st_q.unlock && !st_q.enable
    |=> !st_q.enable && st_q.intSt[CSM_INT_PROT_BIT])
    else $error("locked mode write was not discarded");

  a_mode_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_b) // see RL5
    addrPhase && !hwrite && (haddr == CSM_ADDR_MODE) |=> (hrdata[31:1] == 31'h0))
    else $error("mode register upper bits not zero");

  a_pause_blocks: assert property (@(posedge core_clk) disable iff (!rst_b) // see RL7
    (st_q.mon == CSM_MON_WATCH) && pauseNow |=> (st_q.mon == CSM_MON_PAUSE))
    else $error("stop condition did not pause monitoring");

  // The hold flag lands first; the registered active output follows one cycle later
  a_main_hold: assert property (@(posedge core_clk) disable iff (!rst_b) // see RL8
    mainOscStopBit && subclockSelStatus |=> st_q.mainHold ##1 !monitorActive)
    else $error("deliberate main stop did not pause monitoring");

  a_osc_lost: assert property (@(posedge core_clk) disable iff (!rst_b) // see RL9
    oscLost |=> !monitorActive)
    else $error("stop judged while sampling clock is quiet");

  a_resume_auto: assert property (@(posedge core_clk) disable iff (!rst_b) // see RL14
    (st_q.mon == CSM_MON_PAUSE) && !pauseNow |=> monitorActive)
    else $error("monitoring did not resume automatically");

  a_ext_reset: assert property (@(posedge core_clk) // see RL12
    !rst_b |=> !st_q.enable && !sysResetReq && !monitorActive)
    else $error("external reset did not stop the monitor");

  a_irq_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    stopSeen && st_d.intEn[CSM_INT_STOP_BIT] |=> irq && st_q.intSt[CSM_INT_STOP_BIT])
    else $error("enabled stop event did not raise interrupt");

  // Pulse width checked through the counter, too long for a repetition
  a_reset_len: assert property (@(posedge core_clk) disable iff (!rst_b) // see RL1
    $fell(sysResetReq) |-> $past(st_q.rstCnt) == CSM_RESET_HOLD_CYCLES - 5'h1)
    else $error("reset request width wrong");

  // Registered outputs must show a pause one cycle after its cause
  a_cpu_int_osc: assert property (@(posedge core_clk) disable iff (!rst_b) // see RL10
    cpuOnInternalOsc |=> !monitorActive)
    else $error("monitoring active while CPU runs from internal osc");

  a_start_watch: assert property (@(posedge core_clk) disable iff (!rst_b) // see RL6
    (st_q.mon == CSM_MON_OFF) && st_q.enable && !pauseNow |=> monitorActive)
    else $error("set enable did not start monitoring");

  // Modes not listed as stop conditions must leave the watch running
  a_keep_watch: assert property (@(posedge core_clk) disable iff (!rst_b) // see RL11
    (st_q.mon == CSM_MON_WATCH) && !pauseNow && !stopSeen |=> monitorActive)
    else $error("monitoring dropped without a stop condition");

endmodule // main_clock_stop_monitor
